// file: hdl/cbd_pkg.sv
// Constants, types and encodings for the bus-cycle sequencer and mode decoder
`default_nettype none

package cbd_pkg;

   localparam logic [7:0] VEC_PAGE = 8'hFF;
   localparam logic [7:0] VEC_RESET_LO = 8'hFE;
   localparam logic [7:0] VEC_SWI_LO = 8'hFC;
   localparam logic [7:0] VEC_LO_BIT = 8'h01;
   localparam logic [15:0] SP_RESET = 16'h00FF;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [15:0] HX_RESET = 16'h0000;
   localparam logic [2:0] SWI_PUSH_LAST = 3'h4;

   localparam logic [7:0] OP_PAGE2 = 8'h9E;
   localparam logic [7:0] OP_CBEQ_IXP = 8'h71;
   localparam logic [7:0] OP_PSHA = 8'h87;
   localparam logic [7:0] OP_PULA = 8'h86;
   localparam logic [7:0] OP_SWI = 8'h83;

   // Low nibble of a register/memory opcode selects the operation
   localparam logic [3:0] ROW_SUB = 4'h0;
   localparam logic [3:0] ROW_LDA = 4'h6;
   localparam logic [3:0] ROW_STA = 4'h7;
   localparam logic [3:0] ROW_ADD = 4'hB;
   localparam logic [3:0] COL_BRANCH = 4'h2;

   typedef enum logic [2:0] {
      CBD_CYC_FREE = 3'h0,
      CBD_CYC_FETCH = 3'h1,
      CBD_CYC_READ = 3'h2,
      CBD_CYC_WRITE = 3'h3,
      CBD_CYC_PUSH = 3'h4,
      CBD_CYC_POP = 3'h5,
      CBD_CYC_VECTOR = 3'h6
   } cbd_cycle_t;

   typedef enum logic [3:0] {
      CBD_MODE_INH = 4'h0,
      CBD_MODE_IMM = 4'h1,
      CBD_MODE_DIR = 4'h2,
      CBD_MODE_EXT = 4'h3,
      CBD_MODE_IX = 4'h4,
      indexed_byte_offset_mode = 4'h5,
      indexed_word_offset_mode = 4'h6,
      indexed_postinc_mode = 4'h7,
      stack_byte_offset_mode = 4'h8,
      stack_word_offset_mode = 4'h9,
      CBD_MODE_REL = 4'hA
   } cbd_mode_t;

   typedef enum logic [9:0] {
      ST_VHI = 10'h001,
      ST_VLO = 10'h002,
      ST_FETCH = 10'h004,
      ST_PAGE2 = 10'h008,
      ST_OPR1 = 10'h010,
      ST_OPR2 = 10'h020,
      ST_FREE = 10'h040,
      ST_MEM = 10'h080,
      ST_PUSH = 10'h100,
      ST_POP = 10'h200
   } cbd_state_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic rd;
      logic wr;
      cbd_cycle_t kind;
   } cbd_bus_t;

   typedef struct packed {
      logic v;
      logic h;
      logic i;
      logic n;
      logic z;
      logic c;
   } cbd_flags_t;

   localparam cbd_flags_t FLAGS_RESET = 6'h08;

endpackage : cbd_pkg

`default_nettype wire

// file: hdl/cbd_core.sv
// Bus-cycle sequencer and addressing-mode decoder of the 8-bit core
`default_nettype none

module cbd_core
   import cbd_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] bus_rdata,
   output cbd_bus_t bus,
   output logic [7:0] acc,
   output cbd_flags_t condition_flags_register,
   output cbd_mode_t addr_mode
);

   logic rst_meta_b;
   logic rst_sync_b;

   cbd_state_t state;
   cbd_state_t next_state;
   logic [15:0] pc;
   logic [15:0] next_pc;
   logic [15:0] sp;
   logic [15:0] next_sp;
   logic [15:0] hx;
   logic [15:0] next_hx;
   logic [15:0] ea;
   logic [15:0] next_ea;
   logic [15:0] opr;
   logic [15:0] next_opr;
   logic [7:0] op;
   logic [7:0] next_op;
   logic p2;
   logic next_p2;
   logic [2:0] cnt;
   logic [2:0] next_cnt;
   logic [7:0] vec_lo;
   logic [7:0] next_vec;
   logic [7:0] next_a;
   cbd_flags_t next_flags;
   cbd_mode_t next_mode;
   cbd_bus_t next_bus;

   // Reset release through two stages; the rest of the core uses the copy
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_b <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta_b <= 1'b1;
         rst_sync_b <= rst_meta_b;
      end
   end

   // Decode source: the byte arriving now in opcode cycles, else the held opcode
   wire dec_live = (state == ST_FETCH) || (state == ST_PAGE2);
   wire [7:0] dec_op = dec_live ? bus_rdata : op;
   wire dec_p2 = (state == ST_PAGE2) ? 1'b1 : ((state == ST_FETCH) ? 1'b0 : p2);
   wire [3:0] dec_col = dec_op[7:4];
   wire [3:0] dec_row = dec_op[3:0];

   cbd_mode_t dec_mode;
   always_comb begin
      dec_mode = CBD_MODE_INH;
      if (dec_p2) begin
         if (dec_col == 4'hD) begin
            dec_mode = stack_word_offset_mode;
         end else if (dec_col == 4'hE) begin
            dec_mode = stack_byte_offset_mode;
         end
      end else if (dec_op == OP_CBEQ_IXP) begin
         dec_mode = indexed_postinc_mode;
      end else begin
         unique case (dec_col)
            4'h2: dec_mode = CBD_MODE_REL;
            4'hA: dec_mode = CBD_MODE_IMM;
            4'hB: dec_mode = CBD_MODE_DIR;
            4'hC: dec_mode = CBD_MODE_EXT;
            4'hD: dec_mode = indexed_word_offset_mode;
            4'hE: dec_mode = indexed_byte_offset_mode;
            4'hF: dec_mode = CBD_MODE_IX;
            default: dec_mode = CBD_MODE_INH;
         endcase
      end
   end

   // Operand length follows the mode
   wire dec_two = (dec_mode == CBD_MODE_EXT) || (dec_mode == indexed_word_offset_mode)
      || (dec_mode == stack_word_offset_mode);
   wire dec_none = (dec_mode == CBD_MODE_INH) || (dec_mode == CBD_MODE_IX);
   wire dec_imm = dec_mode == CBD_MODE_IMM;
   wire dec_row_ok = (dec_row == ROW_SUB) || (dec_row == ROW_LDA) || (dec_row == ROW_ADD)
      || ((dec_row == ROW_STA) && !dec_imm);
   wire dec_store = dec_row == ROW_STA;
   wire is_mem_mode = (dec_mode != CBD_MODE_INH) && (dec_mode != CBD_MODE_REL)
      && (dec_mode != indexed_postinc_mode);
   wire is_alu = is_mem_mode && dec_row_ok;
   wire is_br = !dec_p2 && (dec_col == COL_BRANCH);
   wire is_cbeq = !dec_p2 && (dec_op == OP_CBEQ_IXP);
   wire is_psha = !dec_p2 && (dec_op == OP_PSHA);
   wire is_pula = !dec_p2 && (dec_op == OP_PULA);
   wire is_swi = !dec_p2 && (dec_op == OP_SWI);

   // Where a freshly decoded opcode goes next
   wire [9:0] route_code = (is_alu && dec_none) ? ST_FREE :
      ((is_alu || is_br || is_cbeq) ? ST_OPR1 :
      ((is_psha || is_swi) ? ST_PUSH : (is_pula ? ST_FREE : ST_FETCH)));
   wire cbd_state_t route_state = cbd_state_t'(route_code);

   // Branch condition on the current flags
   cbd_flags_t f;
   assign f = condition_flags_register;
   logic br_cond;
   always_comb begin
      unique case (dec_row)
         4'h0: br_cond = 1'b1;
         4'h4: br_cond = !f.c;
         4'h5: br_cond = f.c;
         4'h6: br_cond = !f.z;
         4'h7: br_cond = f.z;
         4'hA: br_cond = !f.n;
         4'hB: br_cond = f.n;
         default: br_cond = 1'b0;
      endcase
   end

   // Signed offset, reach -128..+127 from the counter past the offset byte
   wire [15:0] rel_ofs = {{8{opr[7]}}, opr[7:0]};
   wire [15:0] pc_inc = pc + 16'h0001;

   // Effective address for the memory modes
   logic [15:0] ea_calc;
   always_comb begin
      unique case (dec_mode)
         CBD_MODE_DIR: ea_calc = {8'h00, opr[7:0]};
         CBD_MODE_EXT: ea_calc = opr;
         indexed_word_offset_mode: ea_calc = hx + opr;
         indexed_byte_offset_mode: ea_calc = hx + {8'h00, opr[7:0]};
         stack_word_offset_mode: ea_calc = sp + opr;
         stack_byte_offset_mode: ea_calc = sp + {8'h00, opr[7:0]};
         default: ea_calc = hx;
      endcase
   end

   // Arithmetic on the 8-bit operand byte
   wire [8:0] sum = {1'b0, acc} + {1'b0, bus_rdata};
   wire [8:0] dif = {1'b0, acc} - {1'b0, bus_rdata};
   wire [4:0] half = {1'b0, acc[3:0]} + {1'b0, bus_rdata[3:0]};
   logic [7:0] alu_a;
   cbd_flags_t alu_flags;
   always_comb begin
      alu_flags = condition_flags_register;
      alu_flags.v = 1'b0;
      unique case (dec_row)
         ROW_ADD: begin
            alu_a = sum[7:0];
            alu_flags.c = sum[8];
            alu_flags.h = half[4];
            alu_flags.v = (acc[7] == bus_rdata[7]) && (sum[7] != acc[7]);
         end
         ROW_SUB: begin
            alu_a = dif[7:0];
            alu_flags.c = dif[8];
            alu_flags.v = (acc[7] != bus_rdata[7]) && (dif[7] != acc[7]);
         end
         ROW_LDA: alu_a = bus_rdata;
         default: alu_a = acc;
      endcase
      alu_flags.n = alu_a[7];
      alu_flags.z = alu_a == 8'h00;
   end

   always_comb begin
      next_state = state;
      next_pc = pc;
      next_sp = sp;
      next_hx = hx;
      next_ea = ea;
      next_opr = opr;
      next_op = op;
      next_p2 = p2;
      next_cnt = cnt;
      next_vec = vec_lo;
      next_a = acc;
      next_flags = condition_flags_register;
      next_mode = addr_mode;
      unique case (state)
         ST_VHI: begin
            next_pc = {bus_rdata, pc[7:0]};
            next_state = ST_VLO;
         end
         ST_VLO: begin
            next_pc = {pc[15:8], bus_rdata};
            next_state = ST_FETCH;
         end
         ST_FETCH, ST_PAGE2: begin
            next_op = bus_rdata;
            next_p2 = dec_p2;
            next_pc = pc_inc;
            next_opr = 16'h0000;
            next_cnt = 3'h0;
            if (!dec_p2 && (bus_rdata == OP_PAGE2)) begin
               next_state = ST_PAGE2;
            end else begin
               next_mode = dec_mode;
               next_state = route_state;
            end
         end
         ST_OPR1: begin
            next_opr = {opr[7:0], bus_rdata};
            next_pc = pc_inc;
            if (dec_two) begin
               next_state = ST_OPR2;
            end else if (dec_imm) begin
               next_a = alu_a;
               next_flags = alu_flags;
               next_state = ST_FETCH;
            end else if (is_br) begin
               next_state = br_cond ? ST_FREE : ST_FETCH;
            end else if (is_cbeq) begin
               next_ea = hx;
               next_state = ST_MEM;
            end else begin
               next_state = ST_FREE;
            end
         end
         ST_OPR2: begin
            next_opr = {opr[7:0], bus_rdata};
            next_pc = pc_inc;
            next_state = ST_FREE;
         end
         ST_FREE: begin
            // Internal work only; the bus shows a dummy read
            if (is_br || is_cbeq) begin
               next_pc = pc + rel_ofs;
               next_state = ST_FETCH;
            end else if (is_pula) begin
               next_sp = sp + 16'h0001;
               next_state = ST_POP;
            end else begin
               next_ea = ea_calc;
               next_state = ST_MEM;
            end
         end
         ST_MEM: begin
            if (is_cbeq) begin
               next_hx = hx + 16'h0001;
               next_state = (acc == bus_rdata) ? ST_FREE : ST_FETCH;
            end else begin
               next_a = alu_a;
               next_flags = alu_flags;
               next_state = ST_FETCH;
            end
         end
         ST_PUSH: begin
            next_sp = sp - 16'h0001;
            next_state = ST_FETCH;
            if (is_swi) begin
               if (cnt == SWI_PUSH_LAST) begin
                  next_flags.i = 1'b1;
                  next_vec = VEC_SWI_LO;
                  next_state = ST_VHI;
               end else begin
                  next_cnt = cnt + 3'h1;
                  next_state = ST_PUSH;
               end
            end
         end
         ST_POP: begin
            next_a = bus_rdata;
            next_state = ST_FETCH;
         end
      endcase
   end

   // Byte placed on the stack for this push slot
   logic [7:0] push_byte;
   always_comb begin
      unique case (next_cnt)
         3'h0: push_byte = is_swi ? next_pc[7:0] : acc;
         3'h1: push_byte = next_pc[15:8];
         3'h2: push_byte = next_hx[7:0];
         3'h3: push_byte = acc;
         default: push_byte = {f.v, 2'h3, f.h, f.i, f.n, f.z, f.c};
      endcase
   end

   // Next bus cycle; registered so the bus pins come straight from flops
   wire nb_push = next_state == ST_PUSH;
   wire nb_mem = next_state == ST_MEM;
   wire nb_write = nb_push || (nb_mem && dec_store && !is_cbeq);
   assign next_bus.addr = (next_state == ST_VHI) ? {VEC_PAGE, next_vec} :
      ((next_state == ST_VLO) ? {VEC_PAGE, vec_lo | VEC_LO_BIT} :
      (nb_mem ? next_ea : ((nb_push || (next_state == ST_POP)) ? next_sp : next_pc)));
   assign next_bus.wdata = nb_push ? push_byte : (nb_mem ? acc : 8'h00);
   assign next_bus.wr = nb_write;
   assign next_bus.rd = !nb_write;
   assign next_bus.kind = nb_push ? CBD_CYC_PUSH :
      ((next_state == ST_POP) ? CBD_CYC_POP :
      (nb_mem ? (nb_write ? CBD_CYC_WRITE : CBD_CYC_READ) :
      ((next_state == ST_FREE) ? CBD_CYC_FREE :
      (((next_state == ST_VHI) || (next_state == ST_VLO)) ? CBD_CYC_VECTOR :
      CBD_CYC_FETCH))));

   // Reset enters the vector fetch with the reset vector already on the bus
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         state <= ST_VHI;
         bus <= {VEC_PAGE, VEC_RESET_LO, 8'h00, 1'b1, 1'b0, CBD_CYC_VECTOR};
         pc <= PC_RESET;
         sp <= SP_RESET;
         hx <= HX_RESET;
         ea <= 16'h0000;
         opr <= 16'h0000;
         op <= 8'h00;
         p2 <= 1'b0;
         cnt <= 3'h0;
         vec_lo <= VEC_RESET_LO;
         acc <= 8'h00;
         condition_flags_register <= FLAGS_RESET;
         addr_mode <= CBD_MODE_INH;
      end else begin
         state <= next_state;
         bus <= next_bus;
         pc <= next_pc;
         sp <= next_sp;
         hx <= next_hx;
         ea <= next_ea;
         opr <= next_opr;
         op <= next_op;
         p2 <= next_p2;
         cnt <= next_cnt;
         vec_lo <= next_vec;
         acc <= next_a;
         condition_flags_register <= next_flags;
         addr_mode <= next_mode;
      end
   end

endmodule : cbd_core

`default_nettype wire

// file: verif/cbd_mem.sv
// Memory model standing on the far side of the core's bus
`default_nettype none

module cbd_mem import cbd_pkg::*; (
   input wire logic clk,
   input wire cbd_bus_t bus,
   output logic [7:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] m [0:65535];

   // Zero wait states; inverted data outside reads so stale bytes never pass
   assign rdata = bus.rd ? m[bus.addr] : ~m[bus.addr];

   always @(posedge clk) begin
      if (bus.wr) begin
         m[bus.addr] <= bus.wdata;
      end
   end
endmodule : cbd_mem

`default_nettype wire

// file: verif/cbd_core_assertions.sv
// Checker of bus-cycle kinds and ordering at the core's ports
`default_nettype none

module cbd_core_checker import cbd_pkg::*; (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] bus_rdata,
   input wire cbd_bus_t bus,
   input wire logic [7:0] acc,
   input wire cbd_flags_t condition_flags_register,
   input wire cbd_mode_t addr_mode
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   property p_free_read; bus.kind == CBD_CYC_FREE |-> bus.rd && !bus.wr; endproperty
   a_free_read: assert property (p_free_read) else $error("free cycle not a read");
   property p_free_once; bus.kind == CBD_CYC_FREE |=> bus.kind != CBD_CYC_FREE; endproperty
   a_free_once: assert property (p_free_once) else $error("free cycle too long");
   property p_wr_kind; bus.wr |-> bus.kind inside {CBD_CYC_WRITE, CBD_CYC_PUSH}; endproperty
   a_wr_kind: assert property (p_wr_kind) else $error("write in wrong cycle");
   property p_opnd_write; bus.kind == CBD_CYC_WRITE |-> bus.wr && bus.wdata == acc; endproperty
   a_opnd_write: assert property (p_opnd_write) else $error("operand write bad");
   property p_push_write; bus.kind == CBD_CYC_PUSH |-> bus.wr && !bus.rd; endproperty
   a_push_write: assert property (p_push_write) else $error("push not a write");
   property p_push_step;
      bus.kind == CBD_CYC_PUSH && $past(bus.kind) == CBD_CYC_PUSH
         |-> bus.addr == $past(bus.addr) - 16'h0001;
   endproperty
   a_push_step: assert property (p_push_step) else $error("push address step");
   property p_pop_read; bus.kind == CBD_CYC_POP |-> bus.rd && !bus.wr; endproperty
   a_pop_read: assert property (p_pop_read) else $error("pop not a read");
   property p_vec_page; bus.kind == CBD_CYC_VECTOR |-> bus.rd && bus.addr[15:8] == VEC_PAGE;
   endproperty
   a_vec_page: assert property (p_vec_page) else $error("vector off top page");
   property p_vec_order;
      bus.kind == CBD_CYC_VECTOR && bus.addr[0]
         |-> $past(bus.kind) == CBD_CYC_VECTOR && $past(bus.addr) == {bus.addr[15:1], 1'b0};
   endproperty
   a_vec_order: assert property (p_vec_order) else $error("vector low before high");
   property p_fetch_seq;
      bus.kind == CBD_CYC_FETCH && $past(bus.kind) == CBD_CYC_FETCH
         |-> bus.addr == $past(bus.addr) + 16'h0001;
   endproperty
   a_fetch_seq: assert property (p_fetch_seq) else $error("fetch not sequential");
   property p_pop_load; bus.kind == CBD_CYC_POP |=> acc == $past(bus_rdata); endproperty
   a_pop_load: assert property (p_pop_load) else $error("pop byte not restored");
   property p_vec_mask; bus.kind == CBD_CYC_VECTOR |-> condition_flags_register.i; endproperty
   a_vec_mask: assert property (p_vec_mask) else $error("mask clear in vector fetch");
   property p_pop_mode; bus.kind == CBD_CYC_POP |-> addr_mode == CBD_MODE_INH; endproperty
   a_pop_mode: assert property (p_pop_mode) else $error("pop outside inherent op");
endmodule : cbd_core_checker

bind cbd_core cbd_core_checker u_checker (
   .clk(clk), .rst_b(rst_b), .bus_rdata(bus_rdata), .bus(bus), .acc(acc),
   .condition_flags_register(condition_flags_register), .addr_mode(addr_mode)
);

`default_nettype wire

// file: verif/cpu_bus_cycle_and_mode_decoder_bench.sv
// Self-checking bench: program rows, branches and a software interrupt
`default_nettype none

module cpu_bus_cycle_and_mode_decoder_bench import cbd_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct {
      logic [31:0] code;
      int n;
      cbd_cycle_t kind;
      logic [15:0] addr;
      logic [7:0] acc;
      cbd_mode_t mode;
   } cbd_row_t;

   localparam int NROW = 12;
   // Read rows take their accumulator value from the fill pattern
   cbd_row_t rows [NROW] = '{
      '{32'hA63C0000, 2, CBD_CYC_FETCH, 16'h0100, 8'h3C, CBD_MODE_IMM},
      '{32'hC6123400, 3, CBD_CYC_READ, 16'h1234, 8'h00, CBD_MODE_EXT},
      '{32'hD6023400, 3, CBD_CYC_READ, 16'h0234, 8'h00, indexed_word_offset_mode},
      '{32'hE6400000, 2, CBD_CYC_READ, 16'h0040, 8'h00, indexed_byte_offset_mode},
      '{32'hF6000000, 1, CBD_CYC_READ, 16'h0000, 8'h00, CBD_MODE_IX},
      '{32'h9ED60020, 4, CBD_CYC_READ, 16'h011F, 8'h00, stack_word_offset_mode},
      '{32'h9EE63000, 3, CBD_CYC_READ, 16'h012F, 8'h00, stack_byte_offset_mode},
      '{32'hB6550000, 2, CBD_CYC_READ, 16'h0055, 8'h00, CBD_MODE_DIR},
      '{32'h7100F600, 3, CBD_CYC_READ, 16'h0001, 8'h00, indexed_postinc_mode},
      '{32'hA65CE720, 4, CBD_CYC_WRITE, 16'h0020, 8'h5C, indexed_byte_offset_mode},
      '{32'hA6118786, 4, CBD_CYC_POP, 16'h00FF, 8'h11, CBD_MODE_INH},
      '{32'h9ED70040, 4, CBD_CYC_WRITE, 16'h013F, 8'h00, stack_word_offset_mode}
   };
   // Extremes of reach, never-taken, then a taken and an untaken zero test
   logic [15:0] br [5] = '{16'h207F, 16'h2080, 16'h2110, 16'h2605, 16'h2705};
   logic [15:0] bt [5] = '{16'h0181, 16'h0082, 16'h0103, 16'h0107, 16'h0103};
   logic [7:0] sw [5] = '{8'h03, 8'h01, 8'h00, 8'h80, 8'h6C};

   logic clk;
   logic rst_b;
   logic [7:0] bus_rdata;
   cbd_bus_t bus;
   logic [7:0] acc;
   cbd_flags_t flags;
   cbd_mode_t mode;
   cbd_bus_t tr [16];
   cbd_mode_t trm [16];
   int fail_count = 0;
   int check_count = 0;
   int cycles = 0;
   int k;
   logic seen;
   logic [7:0] exp;

   cbd_mem mem (.clk(clk), .bus(bus), .rdata(bus_rdata));

   cbd_core dut (
      .clk(clk),
      .rst_b(rst_b),
      .bus_rdata(bus_rdata),
      .bus(bus),
      .acc(acc),
      .condition_flags_register(flags),
      .addr_mode(mode)
   );

   function automatic logic [7:0] pat(input logic [15:0] a);
      return a[7:0] ^ {a[11:8], a[15:12]} ^ 8'hA5;
   endfunction : pat

   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask : chk

   task automatic conclude();
      if (fail_count == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : conclude

   // Fresh image and reset per program, so earlier writes cannot leak
   task automatic run(input logic [31:0] code, input int n);
      cbd_bus_t p1;
      cbd_bus_t p2;
      int i;
      @(posedge clk);
      #2;
      for (int a = 0; a < 65536; a++) mem.m[a] = pat(a[15:0]);
      for (int a = 0; a < 24; a++) mem.m[256 + a] = (a < n) ? code[31 - 8 * a -: 8] : 8'h9D;
      mem.m[16'hFFFE] = 8'h01;
      mem.m[16'hFFFF] = 8'h00;
      mem.m[16'hFFFC] = 8'h02;
      mem.m[16'hFFFD] = 8'h00;
      rst_b = 1'b0;
      repeat (10) @(posedge clk);
      chk("reset flags", 16'h0008, {10'h000, flags});
      #2;
      rst_b = 1'b1;
      i = 0;
      p1 = bus;
      p2 = bus;
      @(negedge clk);
      while (bus.kind !== CBD_CYC_FETCH && i < 12) begin
         p2 = p1;
         p1 = bus;
         i++;
         @(negedge clk);
      end
      chk("vector high", 16'hFFFE, p2.addr);
      chk("vector low", 16'hFFFF, p1.addr);
      chk("first fetch", 16'h0100, bus.addr);
      for (int j = 0; j < 16; j++) begin
         tr[j] = bus;
         trm[j] = mode;
         @(negedge clk);
      end
   endtask : run

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Twenty short runs of about thirty cycles each
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         conclude();
      end
   end

   initial begin
      rst_b = 1'b0;
      for (int r = 0; r < NROW; r++) begin
         run(rows[r].code, rows[r].n);
         k = 0;
         seen = 1'b0;
         for (int j = 0; j < 16; j++) begin
            if (tr[j].kind inside {CBD_CYC_READ, CBD_CYC_WRITE, CBD_CYC_POP}) k = j;
            if (trm[j] === rows[r].mode) seen = 1'b1;
         end
         exp = (rows[r].kind == CBD_CYC_READ) ? pat(rows[r].addr) : rows[r].acc;
         chk("data kind", {13'h0000, rows[r].kind}, {13'h0000, tr[k].kind});
         chk("data addr", rows[r].addr, tr[k].addr);
         chk("accumulator", {8'h00, exp}, {8'h00, acc});
         chk("mode", 16'h0001, {15'h0000, seen});
         if (rows[r].kind == CBD_CYC_WRITE) begin
            chk("write data", {8'h00, exp}, {8'h00, tr[k].wdata});
         end
      end
      for (int b = 0; b < 5; b++) begin
         run({br[b], 16'h0000}, 2);
         chk("branch target", bt[b], tr[3].addr);
      end
      run(32'hA6808300, 3);
      for (int j = 0; j < 5; j++) begin
         chk("push addr", 16'h00FF - j[15:0], tr[3 + j].addr);
         chk("push data", {8'h00, sw[j]}, {8'h00, tr[3 + j].wdata});
      end
      chk("swi vector", 16'hFFFC, tr[8].addr);
      chk("swi fetch", 16'h0200, tr[10].addr);
      // Signed overflow and half carry on add; borrow on subtract
      run(32'hA67FAB01, 4);
      chk("add result", 16'h0080, {8'h00, acc});
      chk("add flags", 16'h003C, {10'h000, flags});
      run(32'hA600A001, 4);
      chk("sub result", 16'h00FF, {8'h00, acc});
      chk("sub flags", 16'h000D, {10'h000, flags});
      conclude();
   end
endmodule : cpu_bus_cycle_and_mode_decoder_bench

`default_nettype wire
